// *** design/cpuq_pkg.sv ***
// Constants, register map and types of the identification query block
package cpuq_pkg;
    // ==========================================================
    // Register map (byte addresses)
    localparam logic [7:0] ADDR_OPCODE = 8'h00;
    localparam logic [7:0] ADDR_SELECT = 8'h04;
    localparam logic [7:0] ADDR_FLAGS = 8'h08;
    localparam logic [7:0] ADDR_CR4 = 8'h0c;
    localparam logic [7:0] ADDR_RES_A = 8'h10;
    localparam logic [7:0] ADDR_RES_B = 8'h14;
    localparam logic [7:0] ADDR_RES_C = 8'h18;
    localparam logic [7:0] ADDR_RES_D = 8'h1c;
    localparam logic [7:0] ADDR_STATUS = 8'h20;
    localparam logic [7:0] ADDR_CYCLES = 8'h24;
    localparam logic [7:0] ADDR_MODE = 8'h28;
    // ==========================================================
    // Field positions
    localparam int FLAGS_PROBE_BIT = 21;
    localparam int CR4_TSC_BIT = 2;
    localparam int ST_DONE_BIT = 0;
    localparam int ST_BADOP_BIT = 1;
    localparam int ST_FAULT_BIT = 2;
    localparam int ST_BUSY_BIT = 3;
    localparam int STEP_LSB = 0;
    localparam int MODEL_LSB = 4;
    localparam int FAMILY_LSB = 8;
    localparam int TYPE_LSB = 12;
    // ==========================================================
    // Query constants
    localparam logic [15:0] QUERY_OPCODE = 16'h0fa2;
    localparam logic [31:0] SEL_STD0 = 32'h0000_0000;
    localparam logic [31:0] SEL_STD1 = 32'h0000_0001;
    localparam logic [31:0] SEL_STD2 = 32'h0000_0002;
    localparam logic [31:0] SEL_EXT0 = 32'h8000_0000;
    localparam logic [31:0] SEL_EXT1 = 32'h8000_0001;
    localparam logic [31:0] SEL_NAME0 = 32'h8000_0002;
    localparam logic [31:0] SEL_NAME1 = 32'h8000_0003;
    localparam logic [31:0] SEL_NAME2 = 32'h8000_0004;
    localparam logic [31:0] SEL_EXT5 = 32'h8000_0005;
    localparam logic [31:0] MAX_STD_LEVEL = 32'h0000_0002;
    localparam logic [31:0] MAX_EXT_LEVEL = 32'h8000_0005;
    localparam logic [31:0] FEATURE_FLAGS = 32'h0080_8131;
    localparam logic [3:0] PROC_TYPE = 4'h0;
    localparam logic [7:0] TLB_DESC = 8'h70;
    localparam logic [7:0] ONCE_DESC = 8'h01;
    localparam logic [7:0] L1_DESC = 8'h80;
    // ==========================================================
    // Reset values
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [15:0] RST_OPCODE = 16'h0000;
    // ==========================================================
    // Types
    typedef enum logic [0:0] {
        CPUQ_IDLE = 1'b0,
        CPUQ_EXEC = 1'b1
    } cpuq_state_t;
endpackage

// *** design/cpuq_top.sv ***
// Identification query unit with Avalon-MM register access
//
// Contract
// - Opcode 0FA2 starts query, loads four results
// - Flags bit 21 writable and reads back
// - Selector sampled at start picks result set
// - Selector zero returns 2 in EAX
// - Standard maximum ignores extended range
// - Vendor string in EBX, EDX, ECX order
// - Selector one packs stepping, model, family, type
// - Selector one EBX and ECX reserved
// - Selector one EDX bits 0,4,5,8,15,23 set
// - Cycle counter guarded by control bit 2
// - Selector two EAX byte 1 is 70h
// - Selector two EAX byte 0 is 01h
// - Selector two EDX byte 0 is 80h
// - Extended query returns value at least 80000000h
// - Decode extended selectors one through five
// - Extended maximum equals 80000005h
// - Name string 48 bytes, little-endian, NUL padded
`timescale 1ns/1ps
module cpuq_top #(
    // Identity values below are arbitrary
    parameter logic [31:0] VENDOR_B = 32'h7475_654e,
    parameter logic [31:0] VENDOR_D = 32'h436c_6172,
    parameter logic [31:0] VENDOR_C = 32'h2165_726f,
    parameter logic [3:0] FAMILY = 4'h1,
    parameter logic [3:0] MODEL = 4'h2,
    parameter logic [3:0] STEPPING = 4'h0,
    parameter logic [383:0] NAME_STR = {352'h0, 32'h6572_6f43}
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest
);
    import cpuq_pkg::*;

    // ==========================================================
    // Bus handshake
    logic [15:0] opcode;
    logic [31:0] selector;
    logic [31:0] sel_q;
    logic [31:0] flags;
    logic [31:0] cr4;
    logic [31:0] cycles;
    logic user_mode;
    logic st_done;
    logic st_badop;
    logic st_fault;
    cpuq_state_t state;
    logic [31:0] res [4];
    logic [31:0] look [4];
    logic [31:0] bemask;
    logic [31:0] rd_mux;
    logic [31:0] status_word;
    logic [31:0] id_word;
    wire wr_acc = avs_write & ~avs_waitrequest;
    wire rd_acc = avs_read & ~avs_waitrequest;
    wire wr_op = wr_acc & (avs_address == ADDR_OPCODE);
    wire wr_sel = wr_acc & (avs_address == ADDR_SELECT);
    wire wr_flags = wr_acc & (avs_address == ADDR_FLAGS);
    wire wr_cr4 = wr_acc & (avs_address == ADDR_CR4);
    wire wr_stat = wr_acc & (avs_address == ADDR_STATUS);
    wire wr_mode = wr_acc & (avs_address == ADDR_MODE);
    wire op_match = (avs_writedata[15:0] == QUERY_OPCODE) & (&avs_byteenable[1:0]);
    wire start = wr_op & op_match & (state == CPUQ_IDLE);
    wire bad_op = wr_op & ~start;
    wire tsc_locked = cr4[CR4_TSC_BIT] & user_mode;
    wire rd_cyc = rd_acc & (avs_address == ADDR_CYCLES);
    wire [31:0] done_clr = wr_stat ? (avs_writedata & bemask) : RST_WORD;

    assign bemask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                     {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    assign status_word = {28'h0, (state == CPUQ_EXEC), st_fault, st_badop, st_done};
    assign id_word = {16'h0, PROC_TYPE, FAMILY, MODEL, STEPPING};
    assign rd_mux = (avs_address == ADDR_OPCODE) ? {16'h0, opcode} :
                    (avs_address == ADDR_SELECT) ? selector :
                    (avs_address == ADDR_FLAGS) ? flags :
                    (avs_address == ADDR_CR4) ? cr4 :
                    (avs_address == ADDR_RES_A) ? res[0] :
                    (avs_address == ADDR_RES_B) ? res[1] :
                    (avs_address == ADDR_RES_C) ? res[2] :
                    (avs_address == ADDR_RES_D) ? res[3] :
                    (avs_address == ADDR_STATUS) ? status_word :
                    (avs_address == ADDR_CYCLES) ? (tsc_locked ? RST_WORD : cycles) :
                    (avs_address == ADDR_MODE) ? {31'h0, user_mode} : RST_WORD;

    // One wait cycle per access, answer in the cycle waitrequest is low
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= RST_WORD;
        end
        else
        begin
            avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
            if (avs_read & avs_waitrequest)
            begin
                avs_readdata <= rd_mux;
            end
        end
    end

    // ==========================================================
    // Software visible registers
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            opcode <= RST_OPCODE;
            selector <= RST_WORD;
            flags <= RST_WORD;
            cr4 <= RST_WORD;
            user_mode <= 1'b0;
            cycles <= RST_WORD;
        end
        else
        begin
            cycles <= cycles + 32'h0000_0001;
            if (wr_op)
            begin
                opcode <= avs_writedata[15:0];
            end
            if (wr_sel)
            begin
                selector <= (selector & ~bemask) | (avs_writedata & bemask);
            end
            if (wr_flags & avs_byteenable[2])
            begin
                flags[FLAGS_PROBE_BIT] <= avs_writedata[FLAGS_PROBE_BIT];
            end
            if (wr_cr4 & avs_byteenable[0])
            begin
                cr4[CR4_TSC_BIT] <= avs_writedata[CR4_TSC_BIT];
            end
            if (wr_mode & avs_byteenable[0])
            begin
                user_mode <= avs_writedata[0];
            end
        end
    end

    // ==========================================================
    // Status flags, set wins over clear
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            st_done <= 1'b0;
            st_badop <= 1'b0;
            st_fault <= 1'b0;
        end
        else
        begin
            st_done <= (st_done & ~done_clr[ST_DONE_BIT]) | (state == CPUQ_EXEC);
            st_badop <= (st_badop & ~done_clr[ST_BADOP_BIT]) | bad_op;
            st_fault <= (st_fault & ~done_clr[ST_FAULT_BIT]) | (rd_cyc & tsc_locked);
        end
    end

    // ==========================================================
    // Query sequencer
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            state <= CPUQ_IDLE;
            sel_q <= RST_WORD;
        end
        else
        begin
            case (state)
                CPUQ_IDLE:
                begin
                    if (start)
                    begin
                        state <= CPUQ_EXEC;
                        sel_q <= selector;
                    end
                end
                CPUQ_EXEC:
                begin
                    state <= CPUQ_IDLE;
                end
                default:
                begin
                    state <= CPUQ_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // Result lookup, order EAX EBX ECX EDX
    always_comb
    begin
        look[0] = RST_WORD;
        look[1] = RST_WORD;
        look[2] = RST_WORD;
        look[3] = RST_WORD;
        case (sel_q)
            SEL_STD0:
            begin
                look[0] = MAX_STD_LEVEL;
                look[1] = VENDOR_B;
                look[3] = VENDOR_D;
                look[2] = VENDOR_C;
            end
            SEL_STD1:
            begin
                look[0] = id_word;
                look[3] = FEATURE_FLAGS;
            end
            SEL_STD2:
            begin
                look[0] = {16'h0, TLB_DESC, ONCE_DESC};
                look[3] = {24'h0, L1_DESC};
            end
            SEL_EXT0: look[0] = MAX_EXT_LEVEL;
            SEL_EXT1:
            begin
                look[0] = id_word;
                look[3] = FEATURE_FLAGS;
            end
            SEL_NAME0:
            begin
                look[0] = NAME_STR[31:0];
                look[1] = NAME_STR[63:32];
                look[2] = NAME_STR[95:64];
                look[3] = NAME_STR[127:96];
            end
            SEL_NAME1:
            begin
                look[0] = NAME_STR[159:128];
                look[1] = NAME_STR[191:160];
                look[2] = NAME_STR[223:192];
                look[3] = NAME_STR[255:224];
            end
            SEL_NAME2:
            begin
                look[0] = NAME_STR[287:256];
                look[1] = NAME_STR[319:288];
                look[2] = NAME_STR[351:320];
                look[3] = NAME_STR[383:352];
            end
            SEL_EXT5:
            begin
                look[1] = {16'h0, TLB_DESC, ONCE_DESC};
                look[2] = {24'h0, L1_DESC};
            end
            default: look[0] = RST_WORD;
        endcase
    end

    // All four results load together
    for (genvar i = 0; i < 4; i++)
    begin : g_res
        always_ff @(posedge mclk)
        begin
            if (sys_rst)
            begin
                res[i] <= RST_WORD;
            end
            else if (state == CPUQ_EXEC)
            begin
                res[i] <= look[i];
            end
        end
    end

    // ==========================================================
    // Assertions
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    property p_start;
        start |=> (state == CPUQ_EXEC) ##1 (st_done && state == CPUQ_IDLE);
    endproperty
    a_start: assert property (p_start) else $error("query did not run");
    property p_toggle;
        (wr_flags && avs_byteenable[2]) |=> flags[FLAGS_PROBE_BIT] == $past(avs_writedata[FLAGS_PROBE_BIT]);
    endproperty
    a_toggle: assert property (p_toggle) else $error("probe bit not writable");
    property p_sel;
        start |=> sel_q == $past(selector);
    endproperty
    a_sel: assert property (p_sel) else $error("selector not captured");
    property p_std0;
        (state == CPUQ_EXEC && sel_q == SEL_STD0) |=> res[0] == MAX_STD_LEVEL && res[1] == VENDOR_B
            && res[3] == VENDOR_D && res[2] == VENDOR_C;
    endproperty
    a_std0: assert property (p_std0) else $error("level zero wrong");
    property p_std1;
        (state == CPUQ_EXEC && sel_q == SEL_STD1) |=> res[0][31:12] == 20'h0 && res[1] == RST_WORD
            && res[2] == RST_WORD && res[3] == FEATURE_FLAGS;
    endproperty
    a_std1: assert property (p_std1) else $error("level one wrong");
    property p_std2;
        (state == CPUQ_EXEC && sel_q == SEL_STD2) |=> res[0][15:0] == {TLB_DESC, ONCE_DESC}
            && res[3][7:0] == L1_DESC && res[1] == RST_WORD;
    endproperty
    a_std2: assert property (p_std2) else $error("level two wrong");
    property p_ext0;
        (state == CPUQ_EXEC && sel_q == SEL_EXT0) |=> res[0] == MAX_EXT_LEVEL && res[3] == RST_WORD;
    endproperty
    a_ext0: assert property (p_ext0) else $error("extended maximum wrong");

    property p_unknown;
        (state == CPUQ_EXEC && sel_q > MAX_EXT_LEVEL) |=> res[0] == RST_WORD && res[3] == RST_WORD;
    endproperty
    a_unknown: assert property (p_unknown) else $error("unknown level not zero");

    property p_tsc;
        (avs_read && avs_waitrequest && avs_address == ADDR_CYCLES && tsc_locked)
            |=> avs_readdata == RST_WORD ##1 st_fault;
    endproperty
    a_tsc: assert property (p_tsc) else $error("guarded counter leaked");

    property p_wait;
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest;
    endproperty
    a_wait: assert property (p_wait) else $error("bus answer timing wrong");

    c_std0: cover property (start && selector == SEL_STD0 ##2 st_done);
    c_name: cover property (state == CPUQ_EXEC && sel_q == SEL_NAME1);
    c_badop: cover property (bad_op);
    c_fault: cover property (rd_cyc && tsc_locked);
endmodule

// *** verification/cpuq_top_tb.sv ***
// Self-checking testbench of the identification query unit
`timescale 1ns/1ps
module cpuq_top_tb;
    import cpuq_pkg::*;
    // ==========================================================
    // Parameters, identity values are arbitrary
    localparam logic [31:0] VB = 32'h4c4b_4a49;
    localparam logic [31:0] VD = 32'h504f_4e4d;
    localparam logic [31:0] VC = 32'h5453_5251;
    localparam logic [383:0] NM = {336'h0, 48'h366b_636f_6c42};
    localparam int LIMIT = 20000;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    int n_mismatch = 0;
    int n_tests = 0;
    int cycles = 0;
    logic [31:0] r [4];
    logic [31:0] rd;
    logic [31:0] rd2;
    cpuq_top #(.VENDOR_B(VB), .VENDOR_D(VD), .VENDOR_C(VC), .FAMILY(4'h6), .MODEL(4'h9), .STEPPING(4'h3),
        .NAME_STR(NM)) DUT (.mclk(mclk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
    // ==========================================================
    // Clock and timeout
    initial
    begin
        forever #4 mclk = ~mclk;
    end
    always @(posedge mclk)
    begin
        cycles <= cycles + 1;
        if (cycles == LIMIT)
        begin
            n_mismatch++;
            test_done();
        end
    end
    // ==========================================================
    // Shared tasks
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic bus_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
        @(posedge mclk);
        avs_write <= 1'b1;
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        do @(posedge mclk); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
    endtask
    task automatic bus_read(input logic [7:0] a, output logic [31:0] d);
        @(posedge mclk);
        avs_read <= 1'b1;
        avs_address <= a;
        do @(posedge mclk); while (avs_waitrequest !== 1'b0);
        d = avs_readdata;
        avs_read <= 1'b0;
    endtask
    task automatic query(input logic [31:0] sel);
        logic [31:0] st;
        bus_write(ADDR_STATUS, 32'h1, 4'hf);
        bus_write(ADDR_SELECT, sel, 4'hf);
        bus_write(ADDR_OPCODE, {16'h0, QUERY_OPCODE}, 4'hf);
        do bus_read(ADDR_STATUS, st); while (st[ST_DONE_BIT] !== 1'b1);
        for (int i = 0; i < 4; i++)
            bus_read(8'(ADDR_RES_A + 4 * i), r[i]);
    endtask
    // ==========================================================
    // Scenarios
    task automatic t_regs();
        bus_read(ADDR_FLAGS, rd);
        check(rd, 32'h0);
        bus_write(ADDR_FLAGS, 32'hffff_ffff, 4'hf);
        bus_read(ADDR_FLAGS, rd);
        check(rd, 32'h0020_0000);
        bus_write(ADDR_FLAGS, 32'h0, 4'hf);
        bus_read(ADDR_FLAGS, rd);
        check(rd, 32'h0);
        bus_write(8'h3c, 32'hffff_ffff, 4'hf);
        bus_read(8'h3c, rd);
        check(rd, 32'h0);
    endtask
    task automatic t_std();
        query(SEL_STD0);
        check(r[0], 32'h2);
        check(r[1], VB);
        check(r[3], VD);
        check(r[2], VC);
        bus_read(ADDR_OPCODE, rd);
        check(rd, 32'h0000_0fa2);
        query(SEL_STD1);
        check(r[0], 32'h0000_0693);
        check(r[1], 32'h0);
        check(r[2], 32'h0);
        check(r[3], 32'h0080_8131);
        bus_write(ADDR_SELECT, SEL_STD0, 4'hf);
        bus_read(ADDR_RES_A, rd);
        check(rd, 32'h0000_0693);
        query(SEL_STD2);
        check(r[0], 32'h0000_7001);
        check(r[1], 32'h0);
        check(r[2], 32'h0);
        check(r[3], 32'h0000_0080);
    endtask
    task automatic t_ext();
        query(SEL_EXT0);
        check(r[0], 32'h8000_0005);
        query(SEL_EXT1);
        check(r[0], 32'h0000_0693);
        check(r[3], 32'h0080_8131);
        query(SEL_NAME0);
        check(r[0], 32'h636f_6c42);
        check(r[1], 32'h0000_366b);
        check(r[2] | r[3], 32'h0);
        query(SEL_NAME1);
        check(r[0] | r[1] | r[2] | r[3], 32'h0);
        query(SEL_NAME2);
        check(r[0] | r[1] | r[2] | r[3], 32'h0);
        query(SEL_EXT5);
        check(r[0], 32'h0);
        check(r[1], 32'h0000_7001);
        check(r[2], 32'h0000_0080);
    endtask
    task automatic t_unknown();
        logic [31:0] sels [3];
        sels = '{32'h0000_0003, 32'h8000_0006, 32'h7fff_ffff};
        for (int i = 0; i < 3; i++)
        begin
            query(sels[i]);
            check(r[0] | r[1] | r[2] | r[3], 32'h0);
        end
    endtask
    task automatic t_badop();
        query(SEL_STD2);
        bus_write(ADDR_STATUS, 32'h1, 4'hf);
        bus_write(ADDR_SELECT, SEL_STD0, 4'hf);
        bus_write(ADDR_OPCODE, 32'h0000_0fa3, 4'hf);
        bus_read(ADDR_STATUS, rd);
        check(rd & 32'h3, 32'h2);
        bus_write(ADDR_STATUS, 32'h2, 4'hf);
        bus_write(ADDR_OPCODE, {16'h0, QUERY_OPCODE}, 4'hc);
        bus_read(ADDR_STATUS, rd);
        check(rd & 32'h3, 32'h2);
        bus_read(ADDR_RES_A, rd);
        check(rd, 32'h0000_7001);
        bus_write(ADDR_STATUS, 32'h2, 4'hf);
        bus_read(ADDR_STATUS, rd);
        check(rd & 32'h2, 32'h0);
    endtask
    task automatic t_counter();
        query(SEL_STD1);
        check({31'h0, r[3][4]}, 32'h1);
        bus_read(ADDR_CYCLES, rd);
        bus_read(ADDR_CYCLES, rd2);
        check({31'h0, rd2 > rd}, 32'h1);
        bus_write(ADDR_CR4, 32'hffff_ffff, 4'h1);
        bus_read(ADDR_CR4, rd);
        check(rd, 32'h4);
        bus_write(ADDR_MODE, 32'h1, 4'h1);
        bus_read(ADDR_CYCLES, rd);
        check(rd, 32'h0);
        bus_read(ADDR_STATUS, rd);
        check(rd & 32'h4, 32'h4);
        bus_write(ADDR_CR4, 32'h0, 4'h1);
        bus_read(ADDR_CYCLES, rd);
        check({31'h0, rd > rd2}, 32'h1);
        bus_write(ADDR_STATUS, 32'h4, 4'hf);
        bus_read(ADDR_STATUS, rd);
        check(rd & 32'h4, 32'h0);
        bus_write(ADDR_MODE, 32'h0, 4'h1);
    endtask
    // ==========================================================
    // Main sequence
    initial
    begin
        repeat (5) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        check({31'h0, avs_waitrequest}, 32'h1);
        bus_read(ADDR_STATUS, rd);
        check(rd, 32'h0);
        t_regs();
        t_std();
        t_ext();
        t_unknown();
        t_badop();
        t_counter();
        test_done();
    end
endmodule
